// ### shared/bir_pkg.sv
// constants for the bridge interrupt route and status block
// assumes one 100 MHz clock and an apb slave port of 32-bit words
//
// Overview of operation
// - route enable high lets a source reach a host pin; low never
// - each dma controller has its own route enable bit
// - each location monitor has its own route enable bit
// - each mailbox has its own route enable bit
// - error, edge, ack, system fail, power fail each have route enable
// - pending bits read high while outstanding, read-only, zero after reset
// - dma one pending at bit 25, dma zero at bit 24
// - location monitors 3..0 pending at bits 23..20
// - mailboxes 3..0 pending at bits 19..16
// - bits 13..8: bus error, backplane error, edge, ack, sysfail, acfail
// - bits 31:26, 15:14 and 0 always read zero
// - route enable shares status layout, read/write, resets to zero
// - writing one to a clear bit clears pending; zero no effect; reads zero
// - pending only records events while per-source enable is set
package bir_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] BIR_OFF_SRC_ENABLE   = 12'h0448;
	localparam logic [11:0] BIR_OFF_ROUTE_ENABLE = 12'h044C;
	localparam logic [11:0] BIR_OFF_PENDING      = 12'h0450;
	localparam logic [11:0] BIR_OFF_CLEAR        = 12'h0454;
	localparam logic [11:0] BIR_OFF_PIN_MAP_LO   = 12'h0458;
	localparam logic [11:0] BIR_OFF_PIN_MAP_HI   = 12'h045C;
	localparam logic [11:0] BIR_OFF_RAW_SOURCES  = 12'h0460;

	// ---------------------------------------------------------------
	// field layout and reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] BIR_SRC_MASK    = 32'h03FF_3FFE;
	localparam logic [31:0] BIR_RESET_WORD  = 32'h0000_0000;
	localparam int          BIR_NUM_PINS    = 4;
	localparam int          BIR_BIT_DMA1    = 25;
	localparam int          BIR_BIT_DMA0    = 24;
	localparam int          BIR_BIT_LM_LO   = 20;
	localparam int          BIR_BIT_MB_LO   = 16;
	localparam int          BIR_BIT_ACFAIL  = 8;
	localparam int          BIR_BIT_IRQ_LO  = 1;

	typedef enum logic [1:0]
	{
		BIR_IDLE   = 2'b00,
		BIR_ACCESS = 2'b01
	} bir_apb_state_t;

endpackage : bir_pkg

// ### verilog/bir_pin_route.sv
// one host pin: or of pending, routed sources mapped to this pin
// assumes map words hold two bits per status bit position
`timescale 1ns/1ps
`default_nettype none
module bir_pin_route
	import bir_pkg::*;
#(
	parameter int PIN = 0
)
(
	input  wire logic [31:0] pendingBits,
	input  wire logic [31:0] routeBits,
	input  wire logic [63:0] mapBits,
	output logic             pinRequest
);

	logic [31:0] hit;

	genvar g;
	generate
		for (g = 0; g < 32; g++)
		begin : gen_hit
			assign hit[g] = pendingBits[g] & routeBits[g] &
				(mapBits[2*g +: 2] == 2'(PIN));
		end
	endgenerate

	assign pinRequest = |(hit & BIR_SRC_MASK);

endmodule : bir_pin_route
`default_nettype wire

// ### verilog/bir_top.sv
// interrupt gathering with apb registers and four host pins
// assumes sources are synchronous single-cycle or level event inputs
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bir_top
	import bir_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] sourceEvents,
	output logic [3:0]       host_interrupt_pins,
	output logic             irq
);

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [31:0]    srcEnable_r,   srcEnable_nxt;
	logic [31:0]    routeEnable_r, routeEnable_nxt;
	logic [31:0]    pending_r,     pending_nxt;
	logic [63:0]    pinMap_r,      pinMap_nxt;
	logic [31:0]    prdata_r,      prdata_nxt;
	logic           pready_r,      pready_nxt;
	logic           pslverr_r,     pslverr_nxt;
	logic [3:0]     pins_r,        pins_nxt;
	logic           irq_r,         irq_nxt;
	bir_apb_state_t state_r,       state_nxt;
	logic [3:0]     pinReq;

	function automatic logic [31:0] bir_merge
	(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[8*b +: 8] = wd[8*b +: 8];
		end
		return r;
	endfunction : bir_merge

	function automatic logic bir_mapped(input logic [11:0] a);
		return a == BIR_OFF_SRC_ENABLE || a == BIR_OFF_ROUTE_ENABLE ||
			a == BIR_OFF_PENDING || a == BIR_OFF_CLEAR ||
			a == BIR_OFF_PIN_MAP_LO || a == BIR_OFF_PIN_MAP_HI ||
			a == BIR_OFF_RAW_SOURCES;
	endfunction : bir_mapped

	// ---------------------------------------------------------------
	// apb slave and register updates
	// ---------------------------------------------------------------
	logic        doWrite;
	logic        doRead;
	logic [31:0] clearBits;

	always_comb
	begin
		doWrite = 1'b0;
		doRead = 1'b0;
		clearBits = 32'h0000_0000;
		state_nxt = state_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0000_0000;
		srcEnable_nxt = srcEnable_r;
		routeEnable_nxt = routeEnable_r;
		pinMap_nxt = pinMap_r;
		// one wait state: answer registered, ends access next edge
		case (state_r)
			BIR_IDLE:
			begin
				if (psel && penable)
				begin
					state_nxt = BIR_ACCESS;
					pready_nxt = 1'b1;
					pslverr_nxt = !bir_mapped(paddr);
					doWrite = pwrite && bir_mapped(paddr);
					doRead = !pwrite;
				end
			end
			BIR_ACCESS:
			begin
				state_nxt = BIR_IDLE;
			end
			default:
			begin
				state_nxt = BIR_IDLE;
			end
		endcase
		if (doWrite)
		begin
			if (paddr == BIR_OFF_SRC_ENABLE)
				srcEnable_nxt = bir_merge(srcEnable_r, pwdata, pstrb)
					& BIR_SRC_MASK;
			else if (paddr == BIR_OFF_ROUTE_ENABLE)
				routeEnable_nxt = bir_merge(routeEnable_r, pwdata, pstrb)
					& BIR_SRC_MASK;
			else if (paddr == BIR_OFF_CLEAR)
				clearBits = bir_merge(32'h0000_0000, pwdata, pstrb);
			else if (paddr == BIR_OFF_PIN_MAP_LO)
				pinMap_nxt[31:0] = bir_merge(pinMap_r[31:0], pwdata, pstrb);
			else if (paddr == BIR_OFF_PIN_MAP_HI)
				pinMap_nxt[63:32] = bir_merge(pinMap_r[63:32], pwdata,
					pstrb);
		end
		if (doRead)
		begin
			if (paddr == BIR_OFF_SRC_ENABLE)
				prdata_nxt = srcEnable_r;
			else if (paddr == BIR_OFF_ROUTE_ENABLE)
				prdata_nxt = routeEnable_r;
			else if (paddr == BIR_OFF_PENDING)
				prdata_nxt = pending_r & BIR_SRC_MASK;
			else if (paddr == BIR_OFF_PIN_MAP_LO)
				prdata_nxt = pinMap_r[31:0];
			else if (paddr == BIR_OFF_PIN_MAP_HI)
				prdata_nxt = pinMap_r[63:32];
			else if (paddr == BIR_OFF_RAW_SOURCES)
				prdata_nxt = sourceEvents & BIR_SRC_MASK;
			else
				prdata_nxt = 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// pending flags
	// ---------------------------------------------------------------
	// layout of bits 25..1 fixed by BIR_SRC_MASK and the source order
	// bit layout
	always_comb
	begin
		// enable gates capture; set wins over clear
		pending_nxt = ((pending_r & ~clearBits) |
			(sourceEvents & srcEnable_r)) & BIR_SRC_MASK;
	end

	// ---------------------------------------------------------------
	// host pins and summary interrupt
	// ---------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < BIR_NUM_PINS; p++)
		begin : gen_pin
			bir_pin_route #(.PIN(p)) u_route
			(
				.pendingBits (pending_r),
				.routeBits   (routeEnable_r),
				.mapBits     (pinMap_r),
				.pinRequest  (pinReq[p])
			);
		end
	endgenerate

	always_comb
	begin
		pins_nxt = pinReq;
		irq_nxt = |(pending_r & routeEnable_r);
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_r <= BIR_IDLE;
			srcEnable_r <= BIR_RESET_WORD;
			routeEnable_r <= BIR_RESET_WORD;
			pending_r <= BIR_RESET_WORD;
			pinMap_r <= 64'h0000_0000_0000_0000;
			prdata_r <= BIR_RESET_WORD;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			pins_r <= 4'h0;
			irq_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			srcEnable_r <= srcEnable_nxt;
			routeEnable_r <= routeEnable_nxt;
			pending_r <= pending_nxt;
			pinMap_r <= pinMap_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			pins_r <= pins_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign host_interrupt_pins = pins_r;
	assign irq = irq_r;

endmodule : bir_top
`default_nettype wire

// ### testbench/bir_chk.sv
// port checker for bir_top
// assumes one clock domain, bound into every bir_top
`timescale 1ns/1ps
`default_nettype none
module bir_chk
	import bir_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [3:0]  host_interrupt_pins,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_unmapped_err: assert property (pready && paddr > BIR_OFF_RAW_SOURCES
		|-> pslverr) else $error("unmapped access without error");
	a_pend_rsv_zero: assert property (pready && !pwrite
		&& paddr == BIR_OFF_PENDING |-> (prdata & ~BIR_SRC_MASK) == 32'h0)
		else $error("reserved pending bit set");
	a_clear_reads_zero: assert property (pready && !pwrite
		&& paddr == BIR_OFF_CLEAR |-> prdata == 32'h0)
		else $error("clear register read nonzero");
	a_pins_irq_agree: assert property ((|host_interrupt_pins) == irq)
		else $error("pins and summary disagree");
	// only a write can take a pending routed source away
	a_irq_fall_cause: assert property ($fell(irq)
		|-> $past(psel && penable && pwrite)) else $error("irq fell unprompted");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n
		|=> !irq && host_interrupt_pins == 4'h0 && !pready)
		else $error("outputs active after reset");
endmodule : bir_chk
bind bir_top bir_chk u_chk (.*);
`default_nettype wire

// ### testbench/bir_host_model.sv
// host side model: samples the four host interrupt pins
// assumes pins are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module bir_host_model
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] host_interrupt_pins,
	output logic [3:0]      pinsSeen
);
	// host takes levels one edge late
	always_ff @(posedge clk)
		pinsSeen <= rst_n ? host_interrupt_pins : 4'h0;
endmodule : bir_host_model
`default_nettype wire

// ### testbench/test_bir_top.sv
// self-checking bench for bir_top with host model
// assumes bir_chk is bound in by its own file
`timescale 1ns/1ps
`default_nettype none
module test_bir_top
	import bir_pkg::*;
;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, sourceEvents, rd, route;
	logic [3:0]  pstrb, host_interrupt_pins, pinsSeen;
	int          bad_count, check_count, b;

	bir_top dut (.*);
	bir_host_model host (.*);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// one apb transfer, called right after a clock edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	initial
	begin
		#300us;
		bad_count++;
		finish_test();
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, sourceEvents} = '0;
		pstrb = 4'hF;
		rst_n = 1'b0;
		void'($urandom(3));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (b = 0; b < 7; b++)
		begin
			apb(1'b0, BIR_OFF_SRC_ENABLE + 12'(4 * b), '0);
			chk("reset value", rd, '0);
		end
		$display("reset test done");
		route = $urandom;
		apb(1'b1, BIR_OFF_ROUTE_ENABLE, route);
		apb(1'b0, BIR_OFF_ROUTE_ENABLE, '0);
		chk("route", rd, route & BIR_SRC_MASK);
		apb(1'b1, 12'h0500, route);
		chk("unmapped error", err, 1);
		apb(1'b1, BIR_OFF_ROUTE_ENABLE, '0);
		sourceEvents <= '1;
		@(posedge clk);
		sourceEvents <= '0;
		apb(1'b0, BIR_OFF_PENDING, '0);
		chk("uncaptured", rd, '0);
		$display("register test done");
		apb(1'b1, BIR_OFF_SRC_ENABLE, '1);
		apb(1'b1, BIR_OFF_PIN_MAP_LO, 32'h5555_5555);
		apb(1'b1, BIR_OFF_PIN_MAP_HI, 32'hAAAA_AAAA);
		for (b = 0; b < 32; b++)
			if (BIR_SRC_MASK[b])
			begin
				sourceEvents <= 32'h1 << b;
				@(posedge clk);
				sourceEvents <= '0;
				apb(1'b1, BIR_OFF_CLEAR, '0);
				apb(1'b1, BIR_OFF_PENDING, '0);
				apb(1'b0, BIR_OFF_PENDING, '0);
				chk("pending", rd, 32'h1 << b);
				chk("polled pins", host_interrupt_pins, 0);
				apb(1'b1, BIR_OFF_ROUTE_ENABLE, 32'h1 << b);
				@(posedge clk);
				chk("pin", host_interrupt_pins, b < 16 ? 2 : 4);
				chk("host", pinsSeen, b < 16 ? 2 : 4);
				chk("irq", irq, 1);
				apb(1'b1, BIR_OFF_CLEAR, 32'h1 << b);
				apb(1'b0, BIR_OFF_PENDING, '0);
				chk("cleared", rd, '0);
				chk("pins off", host_interrupt_pins, 0);
			end
		$display("source test done");
		finish_test();
	end
endmodule : test_bir_top
`default_nettype wire
